//--- rtl/dfc_map.vh
// Register map and constants of the decimation filter coefficient path
`ifndef DFC_MAP_VH
`define DFC_MAP_VH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define DFC_A_CTRL      4'h0
`define DFC_A_CPTR      4'h1
`define DFC_A_CDATA     4'h2
`define DFC_A_DEC       4'h3
`define DFC_A_START     4'h4
`define DFC_A_FREQ      4'h5
`define DFC_A_STATUS    4'h6

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define DFC_B_DEMOD_OFF  0
`define DFC_B_DC_SKIP    1
`define DFC_B_MIX_SKIP   2
`define DFC_B_PH_RST     3
`define DFC_B_SCALING    4
`define DFC_B_REMOD_SKIP 5
`define DFC_B_TEST_EN    6
`define DFC_B_OVR_EN     7
`define DFC_F_OVR_VAL    10:8
`define DFC_F_RES        13:11
`define DFC_CTRL_RST     14'h0000
`define DFC_DEC_RST      6'h01
`define DFC_RES_16BIT    3'h4
`define DFC_OVR_TEST     3'h6
`define DFC_DEC_MAX      6'h20

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define DFC_SYNC_BASE    7'h11
`define DFC_OUT_SHIFT    13
`define DFC_HIST_LEN     512
`define DFC_DC_SHIFT     4

`endif

//--- rtl/dfc_top.v
// Decimation FIR with coefficient loading, test readout and frame marker
//
// Decided for this implementation: the register addresses and the strobed register port.
`include "dfc_map.vh"

module dfc_top (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire [3:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    input  wire        TX_SYNC,
    input  wire [13:0] ADC_DATA,
    output reg  [15:0] OUT_DATA,
    output reg         OUT_VALID,
    output reg         FRAME_MARK
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    reg  [13:0]  ctrl_ff;
    reg  [7:0]   coeff_ptr_ff;
    reg  [111:0] word_sh_ff;
    reg  [2:0]   word_cnt_ff;
    reg  [5:0]   dec_ff;
    reg  [7:0]   start_ff;
    reg  [15:0]  freq_ff;
    reg  [111:0] coeff_mem [0:255];
    reg  [13:0]  hist_ff [0:`DFC_HIST_LEN-1];
    reg          sync_neg_ff;
    reg          sync_d_ff;
    reg          sync_busy_ff;
    reg  [6:0]   sync_cnt_ff;
    reg  [15:0]  phase_ff;
    reg  [13:0]  adc_q_ff;
    reg  [13:0]  dc_avg_ff;
    reg  [13:0]  dc_out_ff;
    reg  [4:0]   ph_ff;
    reg  signed [37:0] acc_ff;
    reg          test_run_ff;
    reg  [9:0]   tidx_ff;

    // ----------------------------------------------------------------
    // Settings decode
    // ----------------------------------------------------------------
    wire         demod_off = ctrl_ff[`DFC_B_DEMOD_OFF];
    wire         dc_skip   = ctrl_ff[`DFC_B_DC_SKIP];
    wire         mix_skip  = ctrl_ff[`DFC_B_MIX_SKIP];
    wire [2:0]   ovr_val   = ctrl_ff[`DFC_F_OVR_VAL];
    wire [2:0]   out_res   = ctrl_ff[`DFC_F_RES];
    wire [5:0]   m_eff     = (dec_ff == 6'h00) ? 6'h01 :
                             (dec_ff > `DFC_DEC_MAX) ? `DFC_DEC_MAX : dec_ff;
    wire [4:0]   m_last    = m_eff[4:0] - 5'h01;
    wire         trig      = sync_neg_ff & ~sync_d_ff;
    wire         wr_cdata  = WR & (ADDR == `DFC_A_CDATA);
    wire [111:0] nxt_word  = {word_sh_ff[97:0], WDATA[13:0]};
    // Test readout only runs once every companion setting is in place
    wire         test_ok   = ctrl_ff[`DFC_B_TEST_EN] & dc_skip & mix_skip &
                             ctrl_ff[`DFC_B_OVR_EN] & ctrl_ff[`DFC_B_SCALING] &
                             ctrl_ff[`DFC_B_REMOD_SKIP] &
                             (ovr_val == `DFC_OVR_TEST) &
                             (out_res == `DFC_RES_16BIT);
    // Six-bit factor keeps the walk length right at a factor of 32
    wire [9:0]   t_end     = {m_eff, 4'h0} + 10'h001;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff      <= `DFC_CTRL_RST;
            coeff_ptr_ff <= 8'h00;
            word_sh_ff   <= 112'h0;
            word_cnt_ff  <= 3'h0;
            dec_ff       <= `DFC_DEC_RST;
            start_ff     <= 8'h00;
            freq_ff      <= 16'h0000;
            RDATA        <= 16'h0000;
        end else begin
            if (WR) begin
                case (ADDR)
                    `DFC_A_CTRL:  ctrl_ff      <= WDATA[13:0];
                    `DFC_A_CPTR: begin
                        coeff_ptr_ff <= WDATA[7:0];
                        word_cnt_ff  <= 3'h0;
                    end
                    `DFC_A_CDATA: begin
                        // Coefficient 7 arrives first, ends in the top bits
                        word_sh_ff  <= nxt_word;
                        word_cnt_ff <= word_cnt_ff + 3'h1;
                        if (word_cnt_ff == 3'h7)
                            coeff_ptr_ff <= coeff_ptr_ff + 8'h01;
                    end
                    `DFC_A_DEC:   dec_ff   <= WDATA[5:0];
                    `DFC_A_START: start_ff <= WDATA[7:0];
                    `DFC_A_FREQ:  freq_ff  <= WDATA;
                    default: ;
                endcase
            end
            if (RD) begin
                case (ADDR)
                    `DFC_A_CTRL:   RDATA <= {2'h0, ctrl_ff};
                    `DFC_A_CPTR:   RDATA <= {8'h00, coeff_ptr_ff};
                    `DFC_A_CDATA:  RDATA <= {13'h0, word_cnt_ff};
                    `DFC_A_DEC:    RDATA <= {10'h000, dec_ff};
                    `DFC_A_START:  RDATA <= {8'h00, start_ff};
                    `DFC_A_FREQ:   RDATA <= freq_ff;
                    `DFC_A_STATUS: RDATA <= {14'h0, sync_busy_ff,
                                             test_run_ff};
                    default:       RDATA <= 16'h0000;
                endcase
            end else begin
                RDATA <= 16'h0000;
            end
        end
    end

    // Memory has no reset; contents are only meaningful once loaded
    always @(posedge CLK) begin
        if (wr_cdata && word_cnt_ff == 3'h7)
            coeff_mem[coeff_ptr_ff] <= nxt_word;
    end

    // ----------------------------------------------------------------
    // Sync capture and frame marker timing
    // ----------------------------------------------------------------
    // Falling-edge catch leaves half a cycle before the edge detect
    always @(negedge CLK or negedge RST_N) begin
        if (!RST_N)
            sync_neg_ff <= 1'b0;
        else
            sync_neg_ff <= TX_SYNC;
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_d_ff    <= 1'b0;
            sync_busy_ff <= 1'b0;
            sync_cnt_ff  <= 7'h00;
            FRAME_MARK   <= 1'b0;
        end else begin
            sync_d_ff  <= sync_neg_ff;
            FRAME_MARK <= 1'b0;
            if (trig) begin
                // Extra cycle for the DC stage keeps marker and data aligned
                sync_busy_ff <= 1'b1;
                sync_cnt_ff  <= `DFC_SYNC_BASE + {1'b0, m_eff} +
                                {6'h00, ~dc_skip};
            end else if (sync_busy_ff) begin
                sync_cnt_ff <= sync_cnt_ff - 7'h01;
                if (sync_cnt_ff == 7'h01) begin
                    sync_busy_ff <= 1'b0;
                    FRAME_MARK   <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Front stages: DC removal and mixer
    // ----------------------------------------------------------------
    wire signed [14:0] dc_diff  = $signed({adc_q_ff[13], adc_q_ff}) -
                                  $signed({dc_avg_ff[13], dc_avg_ff});
    wire signed [14:0] dc_step  = dc_diff >>> `DFC_DC_SHIFT;
    wire [13:0]        stage_in = dc_skip ? adc_q_ff : dc_out_ff;
    // Square carrier; zero frequency freezes the phase, so input passes as DC once phase is 0 (reset or phase reset on sync)
    wire [13:0]        mixed    = (mix_skip || !phase_ff[15]) ? stage_in :
                                  (~stage_in + 14'h0001);

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            adc_q_ff  <= 14'h0000;
            dc_avg_ff <= 14'h0000;
            dc_out_ff <= 14'h0000;
            phase_ff  <= 16'h0000;
        end else begin
            adc_q_ff  <= ADC_DATA;
            dc_avg_ff <= dc_avg_ff + dc_step[13:0];
            dc_out_ff <= dc_diff[13:0];
            if (trig && ctrl_ff[`DFC_B_PH_RST])
                phase_ff <= 16'h0000;
            else
                phase_ff <= phase_ff + freq_ff;
        end
    end

    // ----------------------------------------------------------------
    // Input history, newest at index 0
    // ----------------------------------------------------------------
    // Every tap lives in flops so all folds finish in one cycle
    genvar g;
    generate
        for (g = 0; g < `DFC_HIST_LEN; g = g + 1) begin : g_hist
            if (g == 0) begin : g_head
                always @(posedge CLK or negedge RST_N) begin
                    if (!RST_N)
                        hist_ff[g] <= 14'h0000;
                    else
                        hist_ff[g] <= mixed;
                end
            end else begin : g_tail
                always @(posedge CLK or negedge RST_N) begin
                    if (!RST_N)
                        hist_ff[g] <= 14'h0000;
                    else
                        hist_ff[g] <= hist_ff[g-1];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Polyphase FIR: one stored block per cycle, M cycles per output
    // ----------------------------------------------------------------
    reg  [111:0]       blk;
    reg  signed [37:0] sum;
    reg  signed [14:0] pair;
    reg  signed [13:0] cw;
    integer            i;
    integer            ia;
    integer            ib;
    integer            mi;

    always @* begin
        blk = coeff_mem[start_ff + {3'h0, ph_ff}];
        sum = 38'sh0;
        mi  = m_eff;
        for (i = 0; i < 8; i = i + 1) begin
            // Mirrored tap index folds with the shifting history
            ia   = mi * i;
            ib   = 16 * mi - mi * (i + 2) + 1 + 2 * ph_ff;
            cw   = blk[i*14 +: 14];
            pair = $signed({hist_ff[ia][13], hist_ff[ia]}) +
                   $signed({hist_ff[ib][13], hist_ff[ib]});
            sum  = sum + cw * pair;
        end
    end

    wire signed [37:0] total   = (ph_ff == 5'h00) ? sum : acc_ff + sum;
    wire [2:0]         sh_amt  = ctrl_ff[`DFC_B_OVR_EN] ? ovr_val : 3'h0;
    wire signed [37:0] scaled  = total >>> (`DFC_OUT_SHIFT + sh_amt);
    // Narrow outputs drop the two lowest bits
    wire [15:0]        fir_out = (out_res == `DFC_RES_16BIT) ? scaled[15:0] :
                                 {scaled[15:2], 2'b00};

    // ----------------------------------------------------------------
    // Coefficient readout walk
    // ----------------------------------------------------------------
    wire [9:0]  pos   = tidx_ff - 10'h001;
    wire [9:0]  fwd   = (pos < {1'b0, m_eff, 3'h0}) ? pos :
                        ({m_eff, 4'h0} - 10'h001 - pos);
    wire [6:0]  blk_j = fwd[9:3];
    // In the forward half even blocks walk upward and odd blocks downward; the mirrored half runs each the other way
    wire [2:0]  slot  = blk_j[0] ? ~fwd[2:0] : fwd[2:0];
    wire [111:0] tblk = coeff_mem[start_ff + {1'b0, blk_j}];
    wire [13:0] tcoef = tblk[slot*14 +: 14];
    wire        tzero = (tidx_ff == 10'h000) || (tidx_ff == t_end);
    wire [15:0] tval  = tzero ? 16'h0000 :
                        {{2{tcoef[13]}}, tcoef};

    // ----------------------------------------------------------------
    // Output stage
    // ----------------------------------------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ph_ff       <= 5'h00;
            acc_ff      <= 38'sh0;
            test_run_ff <= 1'b0;
            tidx_ff     <= 10'h000;
            OUT_DATA    <= 16'h0000;
            OUT_VALID   <= 1'b0;
        end else begin
            acc_ff    <= total;
            OUT_VALID <= 1'b0;
            if (FRAME_MARK || ph_ff == m_last)
                ph_ff <= 5'h00;
            else
                ph_ff <= ph_ff + 5'h01;
            if (FRAME_MARK && test_ok) begin
                test_run_ff <= 1'b1;
                tidx_ff     <= 10'h000;
            end else if (test_run_ff) begin
                tidx_ff <= tidx_ff + 10'h001;
                if (tidx_ff == t_end || !test_ok)
                    test_run_ff <= 1'b0;
            end
            if (demod_off) begin
                OUT_DATA  <= {{2{adc_q_ff[13]}}, adc_q_ff};
                OUT_VALID <= 1'b1;
            end else if (test_run_ff) begin
                OUT_DATA  <= tval;
                OUT_VALID <= 1'b1;
            end else if (ph_ff == m_last && !FRAME_MARK) begin
                OUT_DATA  <= fir_out;
                OUT_VALID <= 1'b1;
            end
        end
    end

endmodule // dfc_top

//--- verification/dfc_capture.sv
// Capture side model: collects output samples of each frame
module dfc_capture (
    input wire        clk,
    input wire        rst_n,
    input wire [15:0] out_data,
    input wire        out_valid,
    input wire        frame_mark
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] got [$];
    // A frame marker opens a fresh capture, as a real receiver aligns on it
    always @(posedge clk) begin
        if (!rst_n || frame_mark)
            got.delete();
        else if (out_valid)
            got.push_back(out_data);
    end
endmodule // dfc_capture

//--- verification/dfc_checker.sv
// Port assertions for the decimation filter coefficient path
module dfc_checker (
    input wire        CLK,
    input wire        RST_N,
    input wire [3:0]  ADDR,
    input wire [15:0] WDATA,
    input wire        WR,
    input wire        RD,
    input wire [15:0] RDATA,
    input wire        TX_SYNC,
    input wire [15:0] OUT_DATA,
    input wire        OUT_VALID,
    input wire        FRAME_MARK
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Shadow of settings and timing counters
    // ----------------------------------------------------------------
    logic [13:0] ctrl_ff;
    logic [5:0]  m_ff, ph_ff;
    logic [7:0]  ptr_ff, cnt_ff;
    logic [2:0]  nc_ff;
    logic [9:0]  wc_ff;
    logic        sync_ff, seen_ff;
    wire  [7:0]  kk = 8'h11 + {2'h0, m_ff} + {7'h0, ~ctrl_ff[1]};
    wire         tst = (ctrl_ff == 14'h26f6);
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_ff <= 14'h0000; m_ff <= 6'h01; ph_ff <= 6'h00;
            ptr_ff <= 8'h00; cnt_ff <= 8'h00; nc_ff <= 3'h0;
            wc_ff <= 10'h000; sync_ff <= 1'b0; seen_ff <= 1'b0;
        end else begin
            sync_ff <= TX_SYNC;
            if (WR && ADDR == 4'h0) ctrl_ff <= WDATA[13:0];
            if (WR && ADDR == 4'h3)
                m_ff <= (WDATA[5:0] == 6'h00) ? 6'h01 :
                        (WDATA[5:0] > 6'h20) ? 6'h20 : WDATA[5:0];
            if (WR && ADDR == 4'h1) begin
                ptr_ff <= WDATA[7:0];
                nc_ff <= 3'h0;
            end else if (WR && ADDR == 4'h2) begin
                nc_ff <= nc_ff + 3'h1;
                if (nc_ff == 3'h7) ptr_ff <= ptr_ff + 8'h01;
            end
            // Saturates so a stale count never matches a later due cycle
            if (TX_SYNC && !sync_ff) cnt_ff <= 8'h01;
            else if (cnt_ff != 8'h00 && cnt_ff != 8'hff)
                cnt_ff <= cnt_ff + 8'h01;
            if (FRAME_MARK) ph_ff <= 6'h00;
            else ph_ff <= (ph_ff >= m_ff) ? 6'h01 : ph_ff + 6'h01;
            if (WR && ADDR == 4'h3) seen_ff <= 1'b0;
            else if (FRAME_MARK) seen_ff <= 1'b1;
            // One extra count: the first sample leaves a cycle after the mark
            if (FRAME_MARK && tst) wc_ff <= {m_ff, 4'h0} + 10'h003;
            else if (wc_ff != 10'h000) wc_ff <= wc_ff - 10'h001;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking dfc_cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_mark_late: assert property (FRAME_MARK |-> cnt_ff == kk + 8'h01)
        else $error("frame marker before or after its due cycle");
    a_mark_due: assert property (cnt_ff == kk + 8'h01 |-> FRAME_MARK)
        else $error("frame marker missing at its due cycle");
    a_mark_pulse: assert property (FRAME_MARK |=> !FRAME_MARK)
        else $error("frame marker longer than one cycle");
    a_demod_off: assert property (ctrl_ff[0] && $past(ctrl_ff[0], 2) |-> OUT_VALID)
        else $error("bypassed demodulator skipped a sample");
    a_decim_phase: assert property (seen_ff && OUT_VALID && !ctrl_ff[6] &&
        !ctrl_ff[0] && !$past(ctrl_ff[0], 2) |-> ph_ff == m_ff)
        else $error("kept sample off the decimation phase");
    a_walk_valid: assert property (wc_ff != 10'h000 &&
        wc_ff != {m_ff, 4'h0} + 10'h003 |-> OUT_VALID)
        else $error("gap inside coefficient readout");
    a_walk_zero: assert property ((wc_ff == {m_ff, 4'h0} + 10'h002 ||
        wc_ff == 10'h001) |-> OUT_DATA == 16'h0000)
        else $error("readout not framed by zeros");
    a_ptr_step: assert property (RD && ADDR == 4'h1 |=> RDATA == {8'h00, ptr_ff})
        else $error("coefficient pointer readback wrong");
endmodule // dfc_checker

bind dfc_top dfc_checker u_dfc_checker (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_SYNC(TX_SYNC),
    .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .FRAME_MARK(FRAME_MARK));

//--- verification/test_dfc_top.sv
// Self-checking bench for the decimation filter coefficient path
`include "dfc_map.vh"
module test_dfc_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct { logic [3:0] a; logic [15:0] d, e; } dfc_row_t;
    logic        CLK, RST_N, WR, RD, TX_SYNC, OUT_VALID, FRAME_MARK, adc_hold;
    logic [3:0]  ADDR;
    logic [15:0] WDATA, RDATA, OUT_DATA;
    logic [13:0] ADC_DATA;
    logic [15:0] exp_q [$];
    int          mismatches, total_checks, nv;
    dfc_row_t    rows [6] = '{'{`DFC_A_DEC, 16'h0000, 16'h0000},
        '{`DFC_A_DEC, 16'h0028, 16'h0028}, '{`DFC_A_FREQ, 16'h1234, 16'h1234},
        '{`DFC_A_STATUS, 16'hffff, 16'h0000}, '{4'hf, 16'hffff, 16'h0000},
        '{`DFC_A_DEC, 16'h0002, 16'h0002}};
    dfc_top u_dfc_top (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .TX_SYNC(TX_SYNC), .ADC_DATA(ADC_DATA),
        .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .FRAME_MARK(FRAME_MARK));
    dfc_capture u_dfc_capture (.clk(CLK), .rst_n(RST_N), .out_data(OUT_DATA),
        .out_valid(OUT_VALID), .frame_mark(FRAME_MARK));
    // ----------------------------------------------------------------
    // Clock, sample ramp and watchdog
    // ----------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) if (!adc_hold) ADC_DATA <= ADC_DATA + 14'h0007;
    initial begin
        #800000;
        mismatches++;
        $display("Watchdog expired");
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [13:0] cv(input int n);
        return 14'h2000 + n[13:0];
    endfunction
    function automatic logic [15:0] sx(input logic [13:0] c);
        return {{2{c[13]}}, c};
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [15:0] e);
        @(posedge CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        chk(what, RDATA, e);
    endtask
    // Block j of factor 2, highest slot shifted in first
    task automatic load_blk(input int j);
        for (int s = 7; s >= 0; s--) wr(`DFC_A_CDATA, {2'h0, cv(2 * s + 1 - j)});
    endtask
    // k is the marker delay in clocks; the marker shows k + 2 falling edges on
    task automatic trig(input int k);
        int n;
        n = 0;
        @(posedge CLK);
        TX_SYNC <= 1'b1;
        while (FRAME_MARK !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        chk("frame marker", {15'h0000, FRAME_MARK}, 16'h0001);
        chk("marker delay", n[15:0], k[15:0] + 16'h0002);
        @(posedge CLK);
        TX_SYNC <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        RST_N = 1'b0; WR = 1'b0; RD = 1'b0; TX_SYNC = 1'b0; adc_hold = 1'b0;
        ADDR = 4'h0; WDATA = 16'h0000; ADC_DATA = 14'h0000;
        mismatches = 0; total_checks = 0;
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        rd("ctrl reset", `DFC_A_CTRL, {2'h0, `DFC_CTRL_RST});
        rd("factor reset", `DFC_A_DEC, {10'h000, `DFC_DEC_RST});
        $display("Test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd("register row", rows[i].a, rows[i].e);
        end
        $display("Test register rows done");
        wr(`DFC_A_CPTR, 16'h00ff);
        load_blk(0);
        rd("pointer wrap", `DFC_A_CPTR, 16'h0000);
        wr(`DFC_A_CPTR, 16'h0000);
        load_blk(0);
        load_blk(1);
        rd("pointer step", `DFC_A_CPTR, 16'h0002);
        $display("Test coefficient load done");
        // 16-bit resolution, shift 6 forced and scaled, DC, mixer and remod skips set, demodulator left on
        wr(`DFC_A_START, 16'h0000);
        wr(`DFC_A_CTRL, 16'h26f6);
        exp_q = {16'h0000};
        for (int i = 0; i < 8; i++) exp_q.push_back(sx(cv(2 * i + 1)));
        for (int i = 7; i >= 0; i--) exp_q.push_back(sx(cv(2 * i)));
        for (int i = 0; i < 8; i++) exp_q.push_back(sx(cv(2 * i)));
        for (int i = 7; i >= 0; i--) exp_q.push_back(sx(cv(2 * i + 1)));
        exp_q.push_back(16'h0000);
        trig(16 + 2 + 1);
        repeat (40) @(posedge CLK);
        foreach (exp_q[i]) chk("readout", u_dfc_capture.got[i], exp_q[i]);
        $display("Test coefficient readout done");
        @(posedge CLK);
        adc_hold <= 1'b1;
        @(posedge CLK);
        ADC_DATA <= 14'h2abc;
        wr(`DFC_A_CTRL, 16'h0001);
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("bypass sample", OUT_DATA, 16'heabc);
        chk("bypass valid", {15'h0000, OUT_VALID}, 16'h0001);
        $display("Test demodulator bypass done");
        adc_hold <= 1'b0;
        wr(`DFC_A_DEC, 16'h0003);
        wr(`DFC_A_CTRL, 16'h0000);
        trig(16 + 3 + 1 + 1);
        nv = 0;
        // Skip the marker's own cycle; the next 12 hold 12 / M kept samples
        @(negedge CLK);
        repeat (12) begin
            @(negedge CLK);
            nv += OUT_VALID ? 1 : 0;
        end
        chk("kept samples", nv[15:0], 16'h0004);
        $display("Test decimation done");
        end_of_test();
    end
endmodule // test_dfc_top
